// >>> src/mimc_defs.svh
// constants of the mac interface mode control block
`ifndef MIMC_DEFS_SVH
`define MIMC_DEFS_SVH

`define MIMC_ADDR_W       5
`define MIMC_DATA_W       16
`define MIMC_ADDR_CTRL    5'h17
`define MIMC_ADDR_ISTAT   5'h1E
`define MIMC_ADDR_IMASK   5'h1F

`define MIMC_CTRL_RST     16'h0041
`define MIMC_CTRL_WMASK   16'h1FF3

`define MIMC_IRQ_W        2

`define MIMC_EB_CODE_14   2'h0
`define MIMC_EB_CODE_2    2'h1
`define MIMC_EB_CODE_6    2'h2
`define MIMC_EB_CODE_10   2'h3
`define MIMC_EB_TOL_14    5'h0E
`define MIMC_EB_TOL_2     5'h02
`define MIMC_EB_TOL_6     5'h06
`define MIMC_EB_TOL_10    5'h0A

`define MIMC_CLK_SHIFT_PS 12'hDAC
`define MIMC_NO_SHIFT_PS  12'h000

`define MIMC_STRAP_LOAD   2'h2
`define MIMC_STRAP_DONE   2'h3

`endif

// >>> src/mimc_pkg.sv
// types of the mac interface mode control block
`include "mimc_defs.svh"

package mimc_pkg;

    typedef enum logic [1:0] {MIMC_MII, MIMC_RMII, MIMC_RGMII} mimc_mode_t;

    typedef enum logic [1:0] {
        MIMC_EB_IDLE,
        MIMC_EB_FILL,
        MIMC_EB_RUN
    } mimc_eb_st_t;

    typedef struct packed {
        logic [2:0] rsvd;
        logic       rx_shift;
        logic       tx_shift_off;
        logic       tx_sync;
        logic       rgmii;
        logic       rmii_shift;
        logic       ref50;
        logic       fifo_norm;
        logic       rmii;
        logic       rev10;
        logic       ovf;
        logic       unf;
        logic [1:0] eb_size;
    } mimc_ctrl_t;

    typedef struct packed {
        logic                    wr;
        logic                    rd;
        logic [`MIMC_ADDR_W-1:0] addr;
        logic [`MIMC_DATA_W-1:0] wdata;
    } mimc_bus_req_t;

    typedef struct packed {
        mimc_mode_t mode;
        logic [11:0] rx_clk_delay_ps;
        logic [11:0] tx_clk_delay_ps;
        logic        rmii_tx_shift_en;
        logic        tx_sync_mode;
        logic        ref_clk_50m;
        logic        fifo_bypass;
        logic        rx_clk_ref50_sel;
    } mimc_cfg_t;

    typedef struct packed {
        logic link_clk;
        logic rec_clk;
        logic rec_bit;
        logic rx_crs;
        logic strap_rgmii;
        logic strap_ref50;
    } mimc_pins_t;

    typedef struct packed {
        mimc_pins_t              sync1;
        mimc_pins_t              sync2;
        logic                    lclk_prev;
        logic                    rclk_prev;
        mimc_ctrl_t              ctrl;
        logic [`MIMC_IRQ_W-1:0]  istat;
        logic [`MIMC_IRQ_W-1:0]  imask;
        logic [`MIMC_DATA_W-1:0] rdata;
        logic [1:0]              strap_cnt;
        logic                    crs_dv;
        logic                    rx_data;
    } mimc_state_t;

endpackage : mimc_pkg

// >>> src/mimc_elastic.sv
// receive elasticity buffer between recovered data and reference clock
`timescale 1ns/1ps
`default_nettype none

module mimc_elastic #(
    parameter int DEPTH = 16,
    parameter int CW    = $clog2(DEPTH) + 1
) (
    input  wire logic          clock,   // block clock
    input  wire logic          rst_n,   // sync reset, active low
    input  wire logic          flush,   // empty and idle the buffer
    input  wire logic [CW-1:0] cap,     // tolerance in bits
    input  wire logic          wr_en,   // recovered bit arrives
    input  wire logic          wr_bit,  // recovered bit value
    input  wire logic          rd_tick, // reference clock edge
    input  wire logic          frame,   // carrier present
    output var  logic          rd_bit,  // bit handed out
    output var  logic          pending, // bits still held
    output var  logic          ovf,     // overflow pulse
    output var  logic          unf      // underflow pulse
);
    import mimc_pkg::*;

    localparam int AW = CW - 1;

    typedef struct packed {
        logic [DEPTH-1:0] mem;
        logic [AW-1:0]    wp;
        logic [AW-1:0]    rp;
        logic [CW-1:0]    cnt;
        mimc_eb_st_t      st;
        logic             rd_bit;
        logic             ovf;
        logic             unf;
    } mimc_eb_t;

    localparam mimc_eb_t EB_RST = '{st: MIMC_EB_IDLE, default: '0};

    mimc_eb_t q;
    mimc_eb_t d;
    logic     do_wr;
    logic     do_rd;

    always_comb begin
        d = q;
        d.ovf = 1'b0;
        d.unf = 1'b0;
        do_wr = wr_en && (q.cnt < cap);
        do_rd = rd_tick && (q.st == MIMC_EB_RUN) && (q.cnt != '0);
        if (wr_en && !do_wr) begin
            d.ovf = 1'b1;
        end
        if (rd_tick && (q.st == MIMC_EB_RUN) && (q.cnt == '0) && frame) begin
            d.unf = 1'b1;
        end
        if (do_wr) begin
            d.mem[q.wp] = wr_bit;
            d.wp = q.wp + 1'b1;
        end
        if (do_rd) begin
            d.rd_bit = q.mem[q.rp];
            d.rp = q.rp + 1'b1;
        end
        d.cnt = q.cnt + CW'(do_wr) - CW'(do_rd);
        unique case (q.st)
            MIMC_EB_IDLE: if (do_wr) d.st = MIMC_EB_FILL;
            // start draining at half of the tolerance
            MIMC_EB_FILL: if (q.cnt >= (cap >> 1) || !frame) begin
                d.st = MIMC_EB_RUN;
            end
            MIMC_EB_RUN: if (q.cnt == '0 && !frame) d.st = MIMC_EB_IDLE;
            default: d.st = MIMC_EB_IDLE;
        endcase
        if (flush) begin
            d = EB_RST;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            q <= EB_RST;
        end else begin
            q <= d;
        end
    end

    assign rd_bit  = q.rd_bit;
    assign pending = (q.cnt != '0);
    assign ovf     = q.ovf;
    assign unf     = q.unf;

endmodule : mimc_elastic

`default_nettype wire

// >>> src/mimc_top.sv
// mac interface mode control: register, straps, crs_dv and rx buffer
// Summary of operation
// RQ1: bit 12 delays rx clock 3.5ns
// RQ2: bit 11 one disables tx clock shift
// RQ3: bit 10 selects shared clock reference
// RQ4: bit 9 selects rgmii, strap default
// RQ5: bit 8 enables rmii tx clock shift
// RQ6: bit 7 picks 50 or 25 MHz
// RQ7: bit 6 zero bypasses fifo, rxclk 50MHz
// RQ8: bit 5 picks rmii or mii
// RQ9: revision 1.0 holds crs_dv until drained
// RQ10: revision 1.2 toggles crs_dv while draining
// RQ11: overflow flag bit 3, cleared by read
// RQ12: underflow flag bit 2, cleared by read
// RQ13: bits 1:0 size elasticity buffer tolerance
// RQ14: software derates buffer at wider ppm
// RQ15: straps load at reset, writable afterwards
//
// The strobed register port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

`include "mimc_defs.svh"

module mimc_top #(
    parameter int EB_DEPTH = 16
) (
    input  wire logic                  clock,       // 20 MHz clock
    input  wire logic                  rst_n,       // sync reset, low
    input  wire mimc_pkg::mimc_bus_req_t bus,       // register request
    output var  logic [`MIMC_DATA_W-1:0] rdata,     // read data
    output var  logic                  irq,         // level interrupt
    input  wire logic                  link_clk,    // rmii reference pin
    input  wire logic                  rec_clk,     // recovered clock pin
    input  wire logic                  rec_bit,     // recovered data pin
    input  wire logic                  rx_crs,      // carrier sense pin
    input  wire logic                  strap_rgmii, // rgmii strap pin
    input  wire logic                  ref_clock_select_strap, // 50m
    output var  logic                  crs_dv,      // carrier/valid
    output var  logic                  rx_data,     // receive bit
    output var  mimc_pkg::mimc_cfg_t   cfg          // interface setup
);
    import mimc_pkg::*;

    localparam mimc_state_t ST_RST = '{
        ctrl: mimc_ctrl_t'(`MIMC_CTRL_RST),
        default: '0
    };

    mimc_state_t q;
    mimc_state_t d;
    mimc_pins_t  pins_in;
    mimc_ctrl_t  wctl;
    mimc_mode_t  mode_c;
    logic [4:0]  eb_cap;
    logic        link_rise;
    logic        rec_rise;
    logic        crs_s;
    logic        wr_ctrl;
    logic        rd_ctrl;
    logic        wr_istat;
    logic        wr_imask;
    logic        eb_flush;
    logic        eb_rd_bit;
    logic        eb_pend;
    logic        eb_ovf;
    logic        eb_unf;
    mimc_ctrl_t  rd_view;
    logic [`MIMC_IRQ_W-1:0] ev_vec;
    logic [`MIMC_IRQ_W-1:0] wr_bits;

    assign pins_in = '{
        link_clk:    link_clk,
        rec_clk:     rec_clk,
        rec_bit:     rec_bit,
        rx_crs:      rx_crs,
        strap_rgmii: strap_rgmii,
        strap_ref50: ref_clock_select_strap
    };

    assign wctl      = mimc_ctrl_t'(bus.wdata);
    assign wr_ctrl   = bus.wr && (bus.addr == `MIMC_ADDR_CTRL);
    assign rd_ctrl   = bus.rd && (bus.addr == `MIMC_ADDR_CTRL);
    assign wr_istat  = bus.wr && (bus.addr == `MIMC_ADDR_ISTAT);
    assign wr_imask  = bus.wr && (bus.addr == `MIMC_ADDR_IMASK);
    assign link_rise = q.sync2.link_clk && !q.lclk_prev;
    assign rec_rise  = q.sync2.rec_clk && !q.rclk_prev;
    assign crs_s     = q.sync2.rx_crs;
    assign rd_view   = mimc_ctrl_t'(rdata);
    assign ev_vec    = {eb_unf, eb_ovf};
    assign wr_bits   = bus.wdata[`MIMC_IRQ_W-1:0];

    // rgmii wins, else rmii or mii
    assign mode_c = q.ctrl.rgmii ? MIMC_RGMII :             // [RQ4]
                    (q.ctrl.rmii ? MIMC_RMII : MIMC_MII);   // [RQ8]

    always_comb begin
        cfg = '0;
        cfg.mode = mode_c;
        cfg.rx_clk_delay_ps = q.ctrl.rx_shift ? `MIMC_CLK_SHIFT_PS
                                              : `MIMC_NO_SHIFT_PS; // [RQ1]
        // inverted sense: one turns the shift off
        cfg.tx_clk_delay_ps = q.ctrl.tx_shift_off ? `MIMC_NO_SHIFT_PS
                                                  : `MIMC_CLK_SHIFT_PS; // [RQ2]
        cfg.tx_sync_mode = q.ctrl.tx_sync;                  // [RQ3]
        cfg.rmii_tx_shift_en = q.ctrl.rmii_shift;           // [RQ5]
        cfg.ref_clk_50m = q.ctrl.ref50;                     // [RQ6]
        cfg.fifo_bypass = !q.ctrl.fifo_norm;                // [RQ7]
        cfg.rx_clk_ref50_sel = !q.ctrl.fifo_norm
                               && (mode_c == MIMC_RMII);    // [RQ7]
    end

    // tolerance in bits for each size code
    always_comb begin
        unique case (q.ctrl.eb_size)
            `MIMC_EB_CODE_14: eb_cap = `MIMC_EB_TOL_14;    // [RQ13]
            `MIMC_EB_CODE_2:  eb_cap = `MIMC_EB_TOL_2;     // [RQ13]
            `MIMC_EB_CODE_6:  eb_cap = `MIMC_EB_TOL_6;     // [RQ13]
            `MIMC_EB_CODE_10: eb_cap = `MIMC_EB_TOL_10;    // [RQ13]
        endcase
    end

    assign eb_flush = cfg.fifo_bypass || (mode_c != MIMC_RMII);

    mimc_elastic #(
        .DEPTH   (EB_DEPTH)
    ) u_elastic (
        .clock   (clock),
        .rst_n   (rst_n),
        .flush   (eb_flush),
        .cap     (eb_cap),
        .wr_en   (rec_rise),
        .wr_bit  (q.sync2.rec_bit),
        .rd_tick (link_rise),
        .frame   (crs_s),
        .rd_bit  (eb_rd_bit),
        .pending (eb_pend),
        .ovf     (eb_ovf),
        .unf     (eb_unf)
    );

    always_comb begin
        d = q;
        d.sync1 = pins_in;
        d.sync2 = q.sync1;
        d.lclk_prev = q.sync2.link_clk;
        d.rclk_prev = q.sync2.rec_clk;

        // strap levels taken once the synchroniser has settled
        if (q.strap_cnt != `MIMC_STRAP_DONE) begin
            d.strap_cnt = q.strap_cnt + 2'h1;
        end
        if (q.strap_cnt == `MIMC_STRAP_LOAD) begin
            d.ctrl.rgmii = q.sync2.strap_rgmii;             // [RQ15]
            d.ctrl.ref50 = q.sync2.strap_ref50;             // [RQ15]
        end

        // status bits and reserved bits ignore writes
        if (wr_ctrl) begin
            d.ctrl = mimc_ctrl_t'((bus.wdata & `MIMC_CTRL_WMASK)
                     | (d.ctrl & ~`MIMC_CTRL_WMASK));       // [RQ15]
        end

        // set beats the clear of the read
        d.ctrl.ovf = eb_ovf || (q.ctrl.ovf && !rd_ctrl);    // [RQ11]
        d.ctrl.unf = eb_unf || (q.ctrl.unf && !rd_ctrl);    // [RQ12]

        d.istat = {eb_unf, eb_ovf} | (q.istat &
                  ~(wr_istat ? bus.wdata[`MIMC_IRQ_W-1:0]
                             : `MIMC_IRQ_W'(0)));
        if (wr_imask) begin
            d.imask = bus.wdata[`MIMC_IRQ_W-1:0];
        end

        d.rdata = '0;
        if (bus.rd) begin
            unique case (bus.addr)
                `MIMC_ADDR_CTRL:  d.rdata = q.ctrl;         // [RQ11]
                `MIMC_ADDR_ISTAT: d.rdata = `MIMC_DATA_W'(q.istat);
                `MIMC_ADDR_IMASK: d.rdata = `MIMC_DATA_W'(q.imask);
                default:          d.rdata = '0;
            endcase
        end

        if (q.ctrl.rev10) begin
            d.crs_dv = crs_s || eb_pend;                    // [RQ9]
        end else if (crs_s) begin
            d.crs_dv = 1'b1;
        end else if (eb_pend) begin
            // carrier gone, data still draining
            if (link_rise) begin
                d.crs_dv = !q.crs_dv;                       // [RQ10]
            end
        end else begin
            d.crs_dv = 1'b0;
        end

        d.rx_data = cfg.fifo_bypass ? q.sync2.rec_bit : eb_rd_bit;
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            q <= ST_RST;
        end else begin
            q <= d;
        end
    end

    assign rdata   = q.rdata;
    assign irq     = |(q.istat & q.imask);
    assign crs_dv  = q.crs_dv;
    assign rx_data = q.rx_data;

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);

    sequence s_ctrl_wr;
        wr_ctrl && q.strap_cnt == `MIMC_STRAP_DONE;
    endsequence

    sequence s_ovf_read;
        rd_ctrl && q.ctrl.ovf && !eb_ovf;
    endsequence

    sequence s_unf_read;
        rd_ctrl && q.ctrl.unf && !eb_unf;
    endsequence

    a_rx_shift_set: assert property (s_ctrl_wr |=> // [RQ1]
        (cfg.rx_clk_delay_ps == `MIMC_CLK_SHIFT_PS) == $past(wctl.rx_shift))
        else $error("rx clock delay does not follow write");
    a_tx_shift_inv: assert property (s_ctrl_wr |=> // [RQ2]
        (cfg.tx_clk_delay_ps == `MIMC_NO_SHIFT_PS)
        == $past(wctl.tx_shift_off))
        else $error("tx clock delay sense wrong");
    a_tx_sync_mode: assert property (s_ctrl_wr |=> // [RQ3]
        cfg.tx_sync_mode == $past(wctl.tx_sync))
        else $error("shared reference mode not taken");
    a_rgmii_select: assert property (s_ctrl_wr |=> // [RQ4]
        (cfg.mode == MIMC_RGMII) == $past(wctl.rgmii))
        else $error("rgmii select wrong");
    a_rmii_tx_shift: assert property (s_ctrl_wr |=> // [RQ5]
        cfg.rmii_tx_shift_en == $past(wctl.rmii_shift))
        else $error("rmii tx shift not taken");
    a_ref_clk_sel: assert property (s_ctrl_wr |=> // [RQ6]
        cfg.ref_clk_50m == $past(wctl.ref50))
        else $error("reference clock select wrong");
    a_fifo_bypass_clk: assert property (s_ctrl_wr // [RQ7]
        and (!wctl.fifo_norm && wctl.rmii && !wctl.rgmii)
        |=> cfg.fifo_bypass && cfg.rx_clk_ref50_sel)
        else $error("bypass without 50 MHz rx clock");
    a_mii_rmii_sel: assert property (s_ctrl_wr and !wctl.rgmii |=> // [RQ8]
        cfg.mode == ($past(wctl.rmii) ? MIMC_RMII : MIMC_MII))
        else $error("mii or rmii select wrong");
    a_rev10_hold: assert property (q.ctrl.rev10 // [RQ9]
        && (crs_s || eb_pend) |=> crs_dv)
        else $error("crs_dv dropped before drain");
    a_rev12_toggle: assert property (!q.ctrl.rev10 && !crs_s // [RQ10]
        && eb_pend && link_rise |=> crs_dv != $past(crs_dv))
        else $error("crs_dv did not toggle while draining");
    a_ovf_sticky: assert property (eb_ovf |=> q.ctrl.ovf) // [RQ11]
        else $error("overflow flag not set");
    a_ovf_cor: assert property (s_ovf_read |=> // [RQ11]
        rd_view.ovf && !q.ctrl.ovf)
        else $error("overflow flag not returned then cleared");
    a_unf_cor: assert property (s_unf_read |=> // [RQ12]
        rd_view.unf && !q.ctrl.unf)
        else $error("underflow flag not returned then cleared");
    a_unf_sticky: assert property (eb_unf |=> q.ctrl.unf) // [RQ12]
        else $error("underflow flag not set");
    a_eb_tolerance: assert property ($changed(q.ctrl.eb_size) // [RQ13]
        && q.ctrl.eb_size == `MIMC_EB_CODE_2 |-> eb_cap == `MIMC_EB_TOL_2)
        else $error("smallest buffer tolerance wrong");
    a_strap_load: assert property (q.strap_cnt == `MIMC_STRAP_LOAD // [RQ15]
        && !wr_ctrl |=> q.ctrl.rgmii == $past(q.sync2.strap_rgmii)
        && q.ctrl.ref50 == $past(q.sync2.strap_ref50))
        else $error("strap level not loaded");

    // register bus
    sequence s_quiet_events;
        !eb_ovf && !eb_unf;
    endsequence

    a_rdata_idle: assert property (!bus.rd |=> rdata == '0)
        else $error("read data not zero outside a read");
    a_rdata_ctrl: assert property (rd_ctrl |=> // [RQ11]
        rdata == $past(q.ctrl))
        else $error("control read data wrong");
    a_rsvd_zero: assert property (q.ctrl.rsvd == '0)
        else $error("reserved control bits not zero");
    a_status_ro: assert property (s_ctrl_wr and s_quiet_events |=> // [RQ12]
        q.ctrl.ovf == $past(q.ctrl.ovf) && q.ctrl.unf == $past(q.ctrl.unf))
        else $error("status bits took a write");
    a_unmapped_wr: assert property ((bus.wr && !wr_ctrl
        && q.strap_cnt == `MIMC_STRAP_DONE) and s_quiet_events
        |=> $stable(q.ctrl))
        else $error("unmapped write changed control");

    // interrupt status and mask
    a_istat_set: assert property (eb_ovf || eb_unf |=>
        (q.istat & $past(ev_vec)) == $past(ev_vec))
        else $error("interrupt status not set by event");
    a_istat_w1c: assert property (wr_istat and s_quiet_events |=>
        (q.istat & $past(wr_bits)) == '0)
        else $error("interrupt status not cleared by write");
    a_imask_wr: assert property (wr_imask |=> q.imask == $past(wr_bits))
        else $error("interrupt mask not written");
    a_irq_raise: assert property (|(ev_vec & q.imask) && !wr_imask |=> irq)
        else $error("unmasked event gave no interrupt");
    a_irq_low: assert property (q.istat == '0 |-> !irq)
        else $error("interrupt without status");

    // receive path
    sequence s_drain_step;
        !q.ctrl.rev10 && !crs_s && eb_pend;
    endsequence

    a_bypass_data: assert property (cfg.fifo_bypass |=> // [RQ7]
        rx_data == $past(q.sync2.rec_bit))
        else $error("bypass data not passed straight");
    a_flush_empty: assert property (eb_flush |=> !eb_pend) // [RQ7]
        else $error("buffer holds bits while flushed");
    a_crs_dv_start: assert property (crs_s |=> crs_dv) // [RQ9]
        else $error("crs_dv low under carrier");
    a_crs_dv_idle: assert property (!crs_s && !eb_pend |=> !crs_dv) // [RQ10]
        else $error("crs_dv high with nothing to send");
    a_rev12_steady: assert property (s_drain_step and !link_rise // [RQ10]
        |=> $stable(crs_dv))
        else $error("crs_dv moved between reference edges");
    a_eb_cap_14: assert property ( // [RQ13]
        q.ctrl.eb_size == `MIMC_EB_CODE_14 |-> eb_cap == `MIMC_EB_TOL_14)
        else $error("largest buffer tolerance wrong");

    // configuration and straps
    a_rgmii_wins: assert property ( // [RQ4]
        q.ctrl.rgmii |-> cfg.mode == MIMC_RGMII)
        else $error("rgmii does not take precedence");
    a_rx_shift_off: assert property ( // [RQ1]
        !q.ctrl.rx_shift |-> cfg.rx_clk_delay_ps == `MIMC_NO_SHIFT_PS)
        else $error("rx clock delayed with shift off");
    a_strap_done: assert property ( // [RQ15]
        q.strap_cnt == `MIMC_STRAP_DONE |=> q.strap_cnt == `MIMC_STRAP_DONE)
        else $error("strap load ran again");

endmodule : mimc_top

`default_nettype wire

// >>> verif/mimc_link_model.sv
// link-side model: reference clock, recovered clock, data and carrier
`timescale 1ns/1ps
`default_nettype none

module mimc_link_model (
    input  wire logic       frame_en, // carrier and recovered clock on
    input  wire logic [1:0] rate,     // recovered period 200 << rate ns
    output var  logic       link_clk, // free-running reference
    output var  logic       rec_clk,  // recovered clock, frames only
    output var  logic       rec_bit,  // recovered data
    output var  logic       rx_crs    // carrier sense
);
    logic [7:0] lfsr;

    assign rx_crs = frame_en;

    // oscillator runs free, phase unrelated to the block clock
    initial begin
        link_clk = 1'b0;
        #37;
        forever #200 link_clk = ~link_clk;
    end

    initial begin
        rec_clk = 1'b0;
        rec_bit = 1'b0;
        lfsr    = 8'hA5;
        forever begin
            if (frame_en === 1'b1) begin
                lfsr    = {lfsr[6:0], lfsr[7] ^ lfsr[5]};
                rec_bit = lfsr[0];
                #(100 << rate) rec_clk = 1'b1;
                #(100 << rate) rec_clk = 1'b0;
            end else begin
                // idle line churns so no stale value is trusted
                rec_bit = ~rec_bit;
                #100;
            end
        end
    end
endmodule : mimc_link_model

`default_nettype wire

// >>> verif/mac_interface_mode_control_bench.sv
// self-checking bench of the mac interface mode control block
`timescale 1ns/1ps
`default_nettype none
`include "mimc_defs.svh"

module mac_interface_mode_control_bench;
    import mimc_pkg::*;
    localparam logic [4:0] A_CT = `MIMC_ADDR_CTRL;
    localparam logic [4:0] A_IS = `MIMC_ADDR_ISTAT;
    localparam logic [4:0] A_IM = `MIMC_ADDR_IMASK;
    logic          clock, rst_n, irq, crs_dv, rx_data;
    logic          link_clk, rec_clk, rec_bit, rx_crs;
    logic          strap_rgmii, strap_ref50, frame_en;
    logic [1:0]    rate;
    logic [2:0]    hist;
    logic [15:0]   rdata, v, d;
    logic [31:0]   seed;
    mimc_bus_req_t bus;
    mimc_cfg_t     cfg;
    int            fail_count, compares, falls;

    mimc_top #(.EB_DEPTH(16)) mimc_top_i (
        .clock(clock), .rst_n(rst_n), .bus(bus), .rdata(rdata), .irq(irq),
        .link_clk(link_clk), .rec_clk(rec_clk), .rec_bit(rec_bit),
        .rx_crs(rx_crs), .strap_rgmii(strap_rgmii),
        .ref_clock_select_strap(strap_ref50), .crs_dv(crs_dv),
        .rx_data(rx_data), .cfg(cfg));

    mimc_link_model mimc_link_model_i (
        .frame_en(frame_en), .rate(rate), .link_clk(link_clk),
        .rec_clk(rec_clk), .rec_bit(rec_bit), .rx_crs(rx_crs));

    always @(negedge crs_dv) falls++;

    // pin level seen two synchroniser stages and one register ago
    always @(posedge clock) hist <= {hist[1:0], rec_bit};

    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : xs

    function automatic logic [31:0] exp_cfg(input logic [15:0] c);
        logic [1:0] m;
        m = c[9] ? 2'h2 : (c[5] ? 2'h1 : 2'h0);
        return {1'b0, m, c[12] ? `MIMC_CLK_SHIFT_PS : `MIMC_NO_SHIFT_PS,
                c[11] ? `MIMC_NO_SHIFT_PS : `MIMC_CLK_SHIFT_PS,
                c[8], c[10], c[7], !c[6], !c[6] && m == 2'h1};
    endfunction : exp_cfg

    task automatic chk(input string n, input logic [31:0] e,
                       input logic [31:0] g);
        compares++;
        if (g !== e) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    task automatic wr(input logic [4:0] a, input logic [15:0] w);
        bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: w};
        @(posedge clock);
        bus <= '0;
        @(posedge clock);
    endtask : wr

    task automatic rchk(input string n, input logic [4:0] a,
                        input logic [15:0] e);
        bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
        @(posedge clock);
        bus <= '0;
        @(negedge clock);
        v = rdata;
        @(posedge clock);
        chk(n, {16'h0000, e}, {16'h0000, v});
    endtask : rchk

    task automatic reset_dut(input logic sg, input logic sr);
        rst_n       <= 1'b0;
        strap_rgmii <= sg;
        strap_ref50 <= sr;
        repeat (3) @(posedge clock);
        rst_n <= 1'b1;
        repeat (4) @(posedge clock);
    endtask : reset_dut

    task automatic frame(input logic [1:0] r, input int n);
        rate     <= r;
        frame_en <= 1'b1;
        repeat (n) @(posedge clock);
        frame_en <= 1'b0;
        repeat (300) @(posedge clock);
    endtask : frame

    task automatic end_sim();
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : end_sim

    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end

    initial begin
        #1_000_000;
        fail_count++;
        end_sim();
    end

    initial begin
        rst_n = 1'b0;
        bus = '0;
        strap_rgmii = 1'b0;
        strap_ref50 = 1'b0;
        frame_en = 1'b0;
        rate = 2'h1;
        seed = 34;
        fail_count = 0;
        compares = 0;
        falls = 0;
        reset_dut(1'b1, 1'b1);
        rchk("ctrl strap", A_CT, 16'h02C1);
        chk("cfg strap", exp_cfg(16'h02C1), {1'b0, cfg});
        wr(A_CT, 16'h0041);
        rchk("ctrl overwrite", A_CT, 16'h0041);
        reset_dut(1'b0, 1'b0);
        rchk("ctrl reset", A_CT, `MIMC_CTRL_RST);
        rchk("mask reset", A_IM, 16'h0000);
        $display("test reset done");
        repeat (8) begin
            d = 16'(xs());
            wr(A_CT, d);
            chk("cfg", exp_cfg(d & `MIMC_CTRL_WMASK), {1'b0, cfg});
            rchk("ctrl rw", A_CT, d & `MIMC_CTRL_WMASK);
        end
        for (int c = 0; c < 4; c++) begin
            wr(A_CT, 16'h0060 | 16'(c));
            rchk("buffer code", A_CT, 16'h0060 | 16'(c));
        end
        wr(5'h05, 16'hFFFF);
        rchk("unmapped", 5'h05, 16'h0000);
        rchk("ctrl kept", A_CT, 16'h0063);
        // bypass passes the idle line churn straight through
        wr(A_CT, 16'h0020);
        repeat (16) begin
            @(negedge clock);
            chk("rx bypass", hist[2], rx_data);
        end
        @(posedge clock);
        $display("test registers done");
        // largest buffer keeps bits in flight when carrier drops
        for (int r = 0; r < 2; r++) begin
            wr(A_CT, (r == 0) ? 16'h0070 : 16'h0060);
            falls = 0;
            frame(2'h1, 480);
            if (r == 0)
                chk("rev10 falls", 1, falls);
            else
                chk("rev12 toggles", 1, falls > 1);
        end
        $display("test drain done");
        wr(A_CT, 16'h0061);
        frame(2'h0, 200);
        rchk("ovf flag", A_CT, 16'h0069);
        rchk("ovf cleared", A_CT, 16'h0061);
        rchk("istat ovf", A_IS, 16'h0001);
        chk("irq masked", 0, irq);
        wr(A_IM, 16'h0003);
        chk("irq on", 1, irq);
        wr(A_IS, 16'h0001);
        chk("irq off", 0, irq);
        frame(2'h2, 200);
        rchk("unf flag", A_CT, 16'h0065);
        rchk("unf cleared", A_CT, 16'h0061);
        chk("irq unf", 1, irq);
        wr(A_IS, 16'h0002);
        rchk("istat clear", A_IS, 16'h0000);
        $display("test events done");
        end_sim();
    end
endmodule : mac_interface_mode_control_bench

`default_nettype wire
